// ---- src/rfat_pkg.sv ----
// Shared constants, access kinds and carriers of the register bank
package rfat_pkg;

  // Widths of the access port and of the fields
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned OFFS_W = 12;
  localparam int unsigned FIELD_W = 8;
  localparam int unsigned WO_W = 16;

  // Module base address; arbitrary default, set per instance
  localparam logic [ADDR_W-1:0] BASE_ADDR_DEF = 32'h0000_1000;

  // Register offsets relative to the module base
  localparam logic [OFFS_W-1:0] OFF_HW_STAT = 12'h000;
  localparam logic [OFFS_W-1:0] OFF_CTRL = 12'h004;
  localparam logic [OFFS_W-1:0] OFF_RC_FLAG = 12'h008;
  localparam logic [OFFS_W-1:0] OFF_STAT = 12'h00C;
  localparam logic [OFFS_W-1:0] OFF_CMD = 12'h010;
  localparam logic [OFFS_W-1:0] OFF_STAT_CLR = 12'h014;
  localparam logic [OFFS_W-1:0] OFF_WO = 12'h018;

  // Values after reset
  localparam logic [FIELD_W-1:0] RST_CTRL = 8'h00;
  localparam logic [FIELD_W-1:0] RST_RC_FLAG = 8'h00;
  localparam logic [FIELD_W-1:0] RST_STAT = 8'h00;
  localparam logic [FIELD_W-1:0] RST_CMD = 8'h00;
  localparam logic [WO_W-1:0] RST_WO = 16'h0000;
  localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

  // Access kinds a field cell can take
  typedef enum logic [2:0]
  {
    ACC_RW = 3'h0,
    ACC_RC = 3'h1,
    ACC_W1C = 3'h2,
    ACC_W1S = 3'h3,
    ACC_WO = 3'h4
  } rfat_access_t;

  // Request from software
  typedef struct packed
  {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rfat_req_t;

  // Answer to software
  typedef struct packed
  {
    logic [DATA_W-1:0] rdata;
    logic err;
  } rfat_rsp_t;

endpackage

// ---- src/rfat_field.sv ----
// One register field cell whose behaviour follows its access kind
`timescale 1ns/1ns
module rfat_field
  import rfat_pkg::*;
#(
  parameter rfat_access_t ACCESS = ACC_RW,
  parameter int unsigned WIDTH = FIELD_W,
  parameter logic [WIDTH-1:0] RESET = {WIDTH{1'b0}}
)
(
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic wr, // Software write to this field
  input wire logic rd, // Software read of this field
  input wire logic [WIDTH-1:0] wdata, // Written value
  input wire logic [WIDTH-1:0] hw_set, // Hardware sets these bits
  input wire logic [WIDTH-1:0] hw_clr, // Hardware clears these bits
  input wire logic [WIDTH-1:0] ext_clr, // Clear from a write-only alias
  output logic [WIDTH-1:0] value, // Stored value
  output logic wr_pulse // One cycle after a write-only write
);

  typedef struct packed
  {
    logic [WIDTH-1:0] value;
    logic wr_pulse;
  } rfat_field_state_t;

  rfat_field_state_t st;
  rfat_field_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Next value by access kind; in RC and W1C cells hardware sets are ORed last so they win
  always_comb
  begin
    logic [WIDTH-1:0] clr;
    clr = ext_clr;
    next_st = st;
    next_st.wr_pulse = 1'b0;
    unique case (ACCESS)
      ACC_RW:
      begin
        if (wr)
          next_st.value = wdata; // R3
      end
      ACC_RC:
      begin
        if (rd)
          next_st.value = {WIDTH{1'b0}}; // R1
        next_st.value = next_st.value | hw_set;
      end
      ACC_W1C:
      begin
        if (wr)
          clr = clr | wdata; // R4
        next_st.value = (st.value & ~clr) | hw_set; // R4
      end
      ACC_W1S:
      begin
        // A software set wins over a hardware clear in the same cycle
        next_st.value = st.value & ~hw_clr;
        if (wr)
          next_st.value = next_st.value | wdata; // R6 R12
      end
      ACC_WO:
      begin
        if (wr)
        begin
          next_st.value = wdata; // R8
          next_st.wr_pulse = 1'b1;
        end
      end
      default:
      begin
        next_st = st;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st.value <= RESET;
      st.wr_pulse <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign value = st.value;
  assign wr_pulse = st.wr_pulse;

endmodule

// ---- src/rfat_regbank.sv ----
// Register bank showing each field access kind behind a simple access port
`timescale 1ns/1ns
// Summary of operation
// R1 - Clear-on-read returns value, then clears it
// R2 - Software writes reset value; read-only unaffected
// R3 - Read-write field stores and returns writes
// R4 - W1C: ones clear own bit, zeros keep
// R5 - Software writes back read status to acknowledge
// R6 - W1S: written zero leaves bit unchanged
// R7 - Write-only W1C clears ones; reads undefined
// R8 - Write-only field accepts writes; reads undefined
// R9 - Reserved bits read as zero
// R10 - Software preserves reserved bits in read-modify-write
// R11 - Registers decoded as offset from module base
// R12 - W1S: written one sets its bit
module rfat_regbank
  import rfat_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BASE_ADDR = BASE_ADDR_DEF
)
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic req_valid, // Access request this cycle
  input wire rfat_req_t req, // Write flag, address, write data
  output logic rsp_valid, // Answer valid, one cycle
  output rfat_rsp_t rsp, // Read data and error flag
  input wire logic [FIELD_W-1:0] hw_status, // Read-only status levels
  output logic [FIELD_W-1:0] ctrl, // Read-write control field
  input wire logic [FIELD_W-1:0] rc_event, // Events for clear-on-read
  input wire logic [FIELD_W-1:0] stat_event, // Events for W1C status
  output logic [FIELD_W-1:0] stat, // Current W1C status bits
  output logic [FIELD_W-1:0] cmd, // Commands set by software
  input wire logic [FIELD_W-1:0] cmd_done, // Hardware clears commands
  output logic [WO_W-1:0] wo_data, // Last write-only value
  output logic wo_strobe // Pulse after a write-only write
);

  typedef struct packed
  {
    logic rsp_valid;
    rfat_rsp_t rsp;
  } rfat_bank_state_t;

  rfat_bank_state_t st;
  rfat_bank_state_t next_st;

  logic hit_base;
  logic [OFFS_W-1:0] offset;
  logic rd_acc;
  logic wr_acc;
  logic wr_ctrl;
  logic rd_rc;
  logic wr_stat;
  logic wr_stat_clr;
  logic wr_cmd;
  logic wr_wo;
  logic [FIELD_W-1:0] wdata_f;
  logic [FIELD_W-1:0] stat_clr;
  logic [FIELD_W-1:0] rc_value;
  logic [FIELD_W-1:0] zero_f;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: the upper bits select this module, the rest the register
  assign hit_base = req.addr[ADDR_W-1:OFFS_W] ==
                    BASE_ADDR[ADDR_W-1:OFFS_W]; // R11
  assign offset = req.addr[OFFS_W-1:0]; // R11
  assign rd_acc = req_valid & ~req.write & hit_base;
  assign wr_acc = req_valid & req.write & hit_base;
  assign wdata_f = req.wdata[FIELD_W-1:0];
  assign zero_f = {FIELD_W{1'b0}};

  // Per-register strobes; writes to the read-only register go nowhere
  assign wr_ctrl = wr_acc & (offset == OFF_CTRL);
  assign rd_rc = rd_acc & (offset == OFF_RC_FLAG);
  assign wr_stat = wr_acc & (offset == OFF_STAT);
  assign wr_stat_clr = wr_acc & (offset == OFF_STAT_CLR);
  assign wr_cmd = wr_acc & (offset == OFF_CMD);
  assign wr_wo = wr_acc & (offset == OFF_WO);

  // Write-only clear alias targets the status bits
  assign stat_clr = wr_stat_clr ? wdata_f : zero_f; // R7

  ////////////////////////////////////////////////////////////////////////////
  // Field cells, one per register that holds state (none for the read-only register or the clear alias)
  rfat_field #(
    .ACCESS(ACC_RW),
    .WIDTH(FIELD_W),
    .RESET(RST_CTRL)
  ) u_ctrl (
    .clk(clk),
    .rstn(rstn),
    .wr(wr_ctrl),
    .rd(1'b0),
    .wdata(wdata_f),
    .hw_set(zero_f),
    .hw_clr(zero_f),
    .ext_clr(zero_f),
    .value(ctrl),
    .wr_pulse()
  );

  // Clear happens on the same edge that captures the read data
  rfat_field #(
    .ACCESS(ACC_RC),
    .WIDTH(FIELD_W),
    .RESET(RST_RC_FLAG)
  ) u_rc_flag (
    .clk(clk),
    .rstn(rstn),
    .wr(1'b0),
    .rd(rd_rc),
    .wdata(zero_f),
    .hw_set(rc_event),
    .hw_clr(zero_f),
    .ext_clr(zero_f),
    .value(rc_value),
    .wr_pulse()
  );

  // Status cleared by writing ones here or through the clear alias
  rfat_field #(
    .ACCESS(ACC_W1C),
    .WIDTH(FIELD_W),
    .RESET(RST_STAT)
  ) u_stat (
    .clk(clk),
    .rstn(rstn),
    .wr(wr_stat),
    .rd(1'b0),
    .wdata(wdata_f),
    .hw_set(stat_event),
    .hw_clr(zero_f),
    .ext_clr(stat_clr),
    .value(stat),
    .wr_pulse()
  );

  rfat_field #(
    .ACCESS(ACC_W1S),
    .WIDTH(FIELD_W),
    .RESET(RST_CMD)
  ) u_cmd (
    .clk(clk),
    .rstn(rstn),
    .wr(wr_cmd),
    .rd(1'b0),
    .wdata(wdata_f),
    .hw_set(zero_f),
    .hw_clr(cmd_done),
    .ext_clr(zero_f),
    .value(cmd),
    .wr_pulse()
  );

  rfat_field #(
    .ACCESS(ACC_WO),
    .WIDTH(WO_W),
    .RESET(RST_WO)
  ) u_wo (
    .clk(clk),
    .rstn(rstn),
    .wr(wr_wo),
    .rd(1'b0),
    .wdata(req.wdata[WO_W-1:0]),
    .hw_set({WO_W{1'b0}}),
    .hw_clr({WO_W{1'b0}}),
    .ext_clr({WO_W{1'b0}}),
    .value(wo_data),
    .wr_pulse(wo_strobe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Answer: read mux with zero-filled reserved bits, error on a miss.
  // Write-only registers read as zero; software must not rely on that.
  always_comb
  begin
    next_st = st;
    next_st.rsp_valid = req_valid;
    next_st.rsp.rdata = RST_RDATA;
    next_st.rsp.err = 1'b0;
    if (req_valid)
    begin
      if (!hit_base)
      begin
        next_st.rsp.err = 1'b1;
      end
      else
      begin
        unique case (offset)
          OFF_HW_STAT:
          begin
            if (!req.write)
              next_st.rsp.rdata = DATA_W'(hw_status); // R2 R9
          end
          OFF_CTRL:
          begin
            if (!req.write)
              next_st.rsp.rdata = DATA_W'(ctrl); // R3 R9
          end
          OFF_RC_FLAG:
          begin
            if (!req.write)
              next_st.rsp.rdata = DATA_W'(rc_value); // R1 R9
          end
          OFF_STAT:
          begin
            if (!req.write)
              next_st.rsp.rdata = DATA_W'(stat); // R4 R9
          end
          OFF_CMD:
          begin
            if (!req.write)
              next_st.rsp.rdata = DATA_W'(cmd); // R6 R9
          end
          OFF_STAT_CLR, OFF_WO:
          begin
            next_st.rsp.rdata = RST_RDATA; // R7 R8
          end
          default:
          begin
            next_st.rsp.err = 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st.rsp_valid <= 1'b0;
      st.rsp.rdata <= RST_RDATA;
      st.rsp.err <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rsp_valid = st.rsp_valid;
  assign rsp = st.rsp;

endmodule

// ---- verification/rfat_regbank_chk.sv ----
// Port assertions for the register bank
`timescale 1ns/1ns
module rfat_regbank_chk
  import rfat_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BASE_ADDR = BASE_ADDR_DEF
)
(
  input wire logic clk, // Clock
  input wire logic rstn, // Reset
  input wire logic req_valid, // Request
  input wire rfat_req_t req, // Request word
  input wire logic rsp_valid, // Answer
  input wire rfat_rsp_t rsp, // Answer word
  input wire logic [FIELD_W-1:0] hw_status, // RO
  input wire logic [FIELD_W-1:0] ctrl, // RW
  input wire logic [FIELD_W-1:0] rc_event, // RC set
  input wire logic [FIELD_W-1:0] stat_event, // W1C set
  input wire logic [FIELD_W-1:0] stat, // W1C
  input wire logic [FIELD_W-1:0] cmd, // W1S
  input wire logic [FIELD_W-1:0] cmd_done, // W1S clr
  input wire logic [WO_W-1:0] wo_data, // WO
  input wire logic wo_strobe // WO pulse
);
////////////////////////////////////////
  // Decode; a foreign upper address never hits
  logic hi;
  logic [OFFS_W-1:0] of;
  logic [FIELD_W-1:0] wd;
  logic [WO_W-1:0] ww;
  assign hi = req.addr[ADDR_W-1:OFFS_W] == BASE_ADDR[ADDR_W-1:OFFS_W];
  assign of = req.addr[OFFS_W-1:0];
  assign wd = req.wdata[FIELD_W-1:0];
  assign ww = req.wdata[WO_W-1:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Hit access; the answer shows state from before the taking edge
  sequence s_acc(logic w, logic [OFFS_W-1:0] o);
    req_valid && req.write == w && hi && of == o;
  endsequence
////////////////////////////////////////
  chk_miss_err: assert property (
    req_valid && !hi |=> rsp_valid && rsp.err)
    else $error("miss without error");
  chk_ctrl_store: assert property (
    s_acc(1'b1, OFF_CTRL) |=> ctrl == $past(wd))
    else $error("ctrl not stored");
  chk_ctrl_read: assert property (
    s_acc(1'b0, OFF_CTRL) |=> rsp.rdata == DATA_W'($past(ctrl)))
    else $error("ctrl read wrong");
  chk_stat_w1c: assert property (
    s_acc(1'b1, OFF_STAT) |=>
      stat == ($past(stat) & ~$past(wd) | $past(stat_event)))
    else $error("w1c update wrong");
  chk_cmd_w1s: assert property (
    s_acc(1'b1, OFF_CMD) |=>
      cmd == ($past(cmd) & ~$past(cmd_done) | $past(wd)))
    else $error("w1s update wrong");
  chk_wo_accept: assert property (
    s_acc(1'b1, OFF_WO) |=> wo_strobe && wo_data == $past(ww))
    else $error("wo write lost");
  chk_rc_clear: assert property (
    s_acc(1'b0, OFF_RC_FLAG) ##1 s_acc(1'b0, OFF_RC_FLAG) |=>
      rsp.rdata == DATA_W'($past(rc_event, 2)))
    else $error("rc not cleared by read");
  chk_rsvd_zero: assert property (
    rsp_valid |-> rsp.rdata[DATA_W-1:FIELD_W] == '0)
    else $error("reserved bits set");
  chk_ro_read: assert property (
    s_acc(1'b0, OFF_HW_STAT) |=> rsp.rdata == DATA_W'($past(hw_status)))
    else $error("ro read wrong");
  chk_alias_clear: assert property (
    s_acc(1'b1, OFF_STAT_CLR) |=>
      stat == ($past(stat) & ~$past(wd) | $past(stat_event)))
    else $error("alias clear wrong");
endmodule
bind rfat_regbank rfat_regbank_chk #(.BASE_ADDR(BASE_ADDR)) u_chk
(
  .clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req),
  .rsp_valid(rsp_valid), .rsp(rsp), .hw_status(hw_status),
  .ctrl(ctrl), .rc_event(rc_event), .stat_event(stat_event),
  .stat(stat), .cmd(cmd), .cmd_done(cmd_done), .wo_data(wo_data),
  .wo_strobe(wo_strobe)
);

// ---- verification/tb_top.sv ----
// Random self-checking bench for the register bank
`timescale 1ns/1ns
module tb_top
  import rfat_pkg::*;
;
////////////////////////////////////////
  // Non-default base so the decode is really exercised
  localparam logic [ADDR_W-1:0] BASE = 32'h0000_3000;
  localparam logic [OFFS_W-1:0] OFFS [9] = '{OFF_HW_STAT, OFF_CTRL,
    OFF_RC_FLAG, OFF_STAT, OFF_CMD, OFF_STAT_CLR, OFF_WO, 12'h006, 12'h01C};
  logic clk, rstn, req_valid, rsp_valid, wo_strobe, m_vld, m_stb, on;
  rfat_req_t req;
  rfat_rsp_t rsp, m_rsp;
  logic [FIELD_W-1:0] hw_status, ctrl, rc_event, stat_event, stat, cmd;
  logic [FIELD_W-1:0] cmd_done, m_ctrl, m_rc, m_stat, m_cmd, wd;
  logic [WO_W-1:0] wo_data, m_wo;
  int n_errors, checks_done;
  assign wd = req.wdata[FIELD_W-1:0];
  rfat_regbank #(.BASE_ADDR(BASE)) u_dut
  (
    .clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp), .hw_status(hw_status), .ctrl(ctrl),
    .rc_event(rc_event), .stat_event(stat_event), .stat(stat), .cmd(cmd),
    .cmd_done(cmd_done), .wo_data(wo_data), .wo_strobe(wo_strobe)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
////////////////////////////////////////
  // Expected answers; write-only places read back as zero
  function automatic logic hit(logic w, logic [OFFS_W-1:0] o);
    return req_valid && req.write == w && req.addr == {BASE[31:12], o};
  endfunction
  function automatic rfat_rsp_t answer();
    rfat_rsp_t a;
    a = '0;
    a.err = req.addr[31:12] != BASE[31:12] || !(req.addr[11:0] inside
      {OFF_HW_STAT, OFF_CTRL, OFF_RC_FLAG, OFF_STAT, OFF_CMD, OFF_STAT_CLR,
      OFF_WO});
    if (!req.write && !a.err)
      case (req.addr[11:0])
        OFF_HW_STAT: a.rdata[7:0] = hw_status;
        OFF_CTRL: a.rdata[7:0] = m_ctrl;
        OFF_RC_FLAG: a.rdata[7:0] = m_rc;
        OFF_STAT: a.rdata[7:0] = m_stat;
        OFF_CMD: a.rdata[7:0] = m_cmd;
        default: a.rdata = '0;
      endcase
    return a;
  endfunction
  // Reference state; events win over clears taken in the same cycle
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      m_vld <= 1'b0;
      m_rsp <= '0;
      m_ctrl <= RST_CTRL;
      m_rc <= RST_RC_FLAG;
      m_stat <= RST_STAT;
      m_cmd <= RST_CMD;
      m_wo <= RST_WO;
      m_stb <= 1'b0;
    end
    else
    begin
      m_vld <= req_valid;
      m_rsp <= req_valid ? answer() : '0;
      m_ctrl <= hit(1'b1, OFF_CTRL) ? wd : m_ctrl;
      m_rc <= (hit(1'b0, OFF_RC_FLAG) ? 8'h00 : m_rc) | rc_event;
      m_stat <= m_stat & ~(hit(1'b1, OFF_STAT) || hit(1'b1, OFF_STAT_CLR)
        ? wd : 8'h00) | stat_event;
      m_cmd <= m_cmd & ~cmd_done | (hit(1'b1, OFF_CMD) ? wd : 8'h00);
      m_wo <= hit(1'b1, OFF_WO) ? req.wdata[WO_W-1:0] : m_wo;
      m_stb <= hit(1'b1, OFF_WO);
    end
  end
////////////////////////////////////////
  task automatic cmp(string n, logic [33:0] e, logic [33:0] g);
    checks_done++;
    if (e !== g)
    begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // Compare off the clock edge, where every output has settled
  always @(negedge clk)
    if (on)
    begin
      cmp("rsp", {m_vld, m_rsp}, {rsp_valid, rsp});
      cmp("ctrl", 34'(m_ctrl), 34'(ctrl));
      cmp("stat", 34'(m_stat), 34'(stat));
      cmp("cmd", 34'(m_cmd), 34'(cmd));
      cmp("wo", 34'({m_stb, m_wo}), 34'({wo_strobe, wo_data}));
    end
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [ADDR_W-1:0] at(logic [OFFS_W-1:0] o);
    return {BASE[31:12], o};
  endfunction
  // One request per cycle, sparse random events alongside
  task automatic drive(logic v, logic w, logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    req_valid <= v;
    req <= {w, a, d};
    hw_status <= 8'($urandom);
    rc_event <= 8'($urandom & $urandom & $urandom);
    stat_event <= 8'($urandom & $urandom & $urandom);
    cmd_done <= 8'($urandom & $urandom);
  endtask
////////////////////////////////////////
  initial
  begin
    int k;
    logic [OFFS_W-1:0] o;
    logic [DATA_W-1:0] d;
    rstn = 1'b0;
    on = 1'b0;
    req_valid = 1'b0;
    req = '0;
    {hw_status, rc_event, stat_event, cmd_done} = '0;
    n_errors = 0;
    checks_done = 0;
    void'($urandom(32'h92FD));
    @(posedge clk);
    on = 1'b1;
    repeat (9) @(posedge clk);
    rstn <= 1'b1;
    // Random traffic; index 9 is a foreign base address
    for (int i = 0; i < 3000; i++)
    begin
      k = $urandom_range(9, 0);
      o = OFFS[k % 9];
      d = $urandom & (o == OFF_WO ? 32'h0000_FFFF : 32'h0000_00FF);
      if (o == OFF_HW_STAT)
        d = '0;
      drive(1'($urandom), 1'($urandom) && o != OFF_RC_FLAG,
        k == 9 ? 32'hFFFF_F004 : at(o), d);
    end
    drive(1'b1, 1'b0, at(OFF_RC_FLAG), '0);
    drive(1'b1, 1'b0, at(OFF_RC_FLAG), '0);
    // Acknowledge status by writing back what was read
    drive(1'b1, 1'b0, at(OFF_STAT), '0);
    drive(1'b0, 1'b0, '0, '0);
    @(negedge clk);
    for (k = 0; k < 4 && rsp_valid !== 1'b1; k++)
      @(negedge clk);
    // A missing answer is counted and the write-back is skipped
    if (k == 4)
      n_errors++;
    else
      drive(1'b1, 1'b1, at(OFF_STAT), rsp.rdata);
    drive(1'b1, 1'b1, at(OFF_HW_STAT), {24'h000000, RST_CTRL});
    drive(1'b1, 1'b0, at(OFF_WO), '0);
    // Reset in mid-run, then read every register back
    drive(1'b0, 1'b0, '0, '0);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (k = 0; k < 7; k++)
      drive(1'b1, 1'b0, at(OFFS[k]), '0);
    drive(1'b0, 1'b0, '0, '0);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule
